// [rtl/rswc_pkg.sv]
package rswc_pkg;

    // ==========================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS      = 100;
    localparam logic [1:0]  BUS_DIV_LAST       = 2'h3;
    localparam logic [2:0]  RESET_DRIVE_CYCLES = 3'h4;
    localparam logic [2:0]  RESET_SAMPLE_GAP   = 3'h2;
    localparam logic [11:0] STOP_DELAY_LONG    = 12'hFE0;
    localparam logic [11:0] STOP_DELAY_SHORT   = 12'h004;
    localparam logic [2:0]  WAIT_WAKEUP_TIME   = 3'h4;

    // ==========================================================
    // states, control and status fields
    typedef enum logic [2:0] {
        RSWC_RUN    = 3'b000,
        RSWC_RDRIVE = 3'b001,
        RSWC_RGAP   = 3'b011,
        RSWC_STOP   = 3'b010,
        RSWC_SWAKE  = 3'b110,
        RSWC_WAIT   = 3'b111,
        RSWC_WWAKE  = 3'b101
    } rswc_state_t;

    typedef struct packed {
        logic enterStop;
        logic enterWait;
        logic stopExitDelaySelect;
        logic irqEdgeSelect;
        logic xMask;
        logic iMask;
    } rswc_ctrl_t;

    typedef struct packed {
        logic resetActive;
        logic resetExternal;
        logic running;
        logic irqPending;
        logic xirqPending;
    } rswc_stat_t;

endpackage

// [rtl/rswc_reset_stop_wait.sv]
`timescale 1ns/10ps
// How it works
// - reset pin seen low in a bus cycle is registered that cycle
// - after recognition the device drives the reset pin low four bus cycles
// - two bus cycles after release the pin is sampled; low means external
// - a one bus cycle pulse is accepted but may be seen as internal
// - bus cycle runs at one quarter of the oscillator clock
// - stop exit waits 4064 bus cycles if delay select is 1, else 4
// - maskable pin falling-edge when edge select is 1, low-level when 0
// - nonmaskable pin exits stop even when its mask bit is 1
// - wait exit by interrupt resumes within 4 bus cycles
// - reset pin also ends wait
module rswc_reset_stop_wait (
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire rswc_pkg::rswc_ctrl_t ctrl,
    input  wire logic               resetPinIn,
    input  wire logic               irqPinN,
    input  wire logic               nonmaskableInterruptPinN,
    output logic                    resetPinOut,
    output logic                    resetPinOe,
    output logic                    busCycle,
    output rswc_pkg::rswc_stat_t    stat
);

    // ==========================================================
    // bus cycle strobe, one in four clocks
    logic [1:0] divCnt_q;
    logic       busTick;
    logic       busCycle_q;
    assign busTick = (divCnt_q == rswc_pkg::BUS_DIV_LAST);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            divCnt_q   <= 2'h0;
            busCycle_q <= 1'b0;
        end else begin
            divCnt_q   <= divCnt_q + 2'h1;
            busCycle_q <= busTick;
        end
    end

    // ==========================================================
    // interrupt sensing
    logic irqLast_q;
    logic irqEdge_q;
    logic irqFall;
    logic irqReq;
    logic xirqReq;
    logic stopWake;
    logic waitWake;
    assign irqFall  = irqLast_q & ~irqPinN;
    assign irqReq   = (ctrl.irqEdgeSelect ? (irqEdge_q | irqFall) : ~irqPinN)
                      & ~ctrl.iMask;
    assign xirqReq  = ~nonmaskableInterruptPinN;
    assign stopWake = xirqReq | irqReq;
    assign waitWake = (xirqReq & ~ctrl.xMask) | irqReq;

    // ==========================================================
    // sequencer
    rswc_pkg::rswc_state_t state_q;
    rswc_pkg::rswc_state_t state_d;
    logic [11:0] cnt_q;
    logic [11:0] cnt_d;
    logic [11:0] stopLoad_q;
    logic        ext_q;
    logic        ext_d;
    logic        resetSeen;
    logic        stateAct;
    assign resetSeen = ~resetPinIn & busTick;
    assign stateAct  = busTick;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        ext_d   = ext_q;
        if (resetSeen && state_q != rswc_pkg::RSWC_RDRIVE
                && state_q != rswc_pkg::RSWC_RGAP) begin
            state_d = rswc_pkg::RSWC_RDRIVE;
            cnt_d   = {9'h000, rswc_pkg::RESET_DRIVE_CYCLES};
        end else if (stateAct) begin
            case (state_q)
                rswc_pkg::RSWC_RDRIVE: begin
                    cnt_d = cnt_q - 12'h001;
                    if (cnt_q == 12'h001) begin
                        state_d = rswc_pkg::RSWC_RGAP;
                        cnt_d   = {9'h000, rswc_pkg::RESET_SAMPLE_GAP};
                    end
                end
                rswc_pkg::RSWC_RGAP: begin
                    cnt_d = cnt_q - 12'h001;
                    if (cnt_q == 12'h001) begin
                        ext_d   = ~resetPinIn;
                        state_d = rswc_pkg::RSWC_RUN;
                    end
                end
                rswc_pkg::RSWC_RUN: begin
                    if (ctrl.enterStop) begin
                        state_d = rswc_pkg::RSWC_STOP;
                    end else if (ctrl.enterWait) begin
                        state_d = rswc_pkg::RSWC_WAIT;
                    end
                end
                rswc_pkg::RSWC_STOP: begin
                    if (stopWake) begin
                        state_d = rswc_pkg::RSWC_SWAKE;
                        cnt_d   = stopLoad_q - 12'h001;
                    end
                end
                rswc_pkg::RSWC_SWAKE: begin
                    cnt_d = cnt_q - 12'h001;
                    if (cnt_q == 12'h001) begin
                        state_d = rswc_pkg::RSWC_RUN;
                    end
                end
                rswc_pkg::RSWC_WAIT: begin
                    if (waitWake) begin
                        state_d = rswc_pkg::RSWC_WWAKE;
                        cnt_d   = {9'h000, rswc_pkg::WAIT_WAKEUP_TIME} - 12'h001;
                    end
                end
                rswc_pkg::RSWC_WWAKE: begin
                    cnt_d = cnt_q - 12'h001;
                    if (cnt_q == 12'h001) begin
                        state_d = rswc_pkg::RSWC_RUN;
                    end
                end
                default: begin
                    state_d = rswc_pkg::RSWC_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= rswc_pkg::RSWC_RUN;
            cnt_q   <= 12'h000;
            ext_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            ext_q   <= ext_d;
        end
    end

    // ==========================================================
    // stop delay capture and irq edge latch
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stopLoad_q <= rswc_pkg::STOP_DELAY_LONG;
        end else if (state_q == rswc_pkg::RSWC_RUN && busTick && ctrl.enterStop) begin
            stopLoad_q <= ctrl.stopExitDelaySelect ? rswc_pkg::STOP_DELAY_LONG
                                                   : rswc_pkg::STOP_DELAY_SHORT;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irqLast_q <= 1'b1;
            irqEdge_q <= 1'b0;
        end else begin
            irqLast_q <= irqPinN;
            if (irqFall) begin
                irqEdge_q <= 1'b1;
            end else if (busTick) begin
                irqEdge_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // outputs
    logic driveLow;
    assign driveLow = (state_d == rswc_pkg::RSWC_RDRIVE);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            resetPinOut <= 1'b0;
            resetPinOe  <= 1'b0;
            stat        <= '0;
        end else begin
            resetPinOut <= 1'b0;
            resetPinOe  <= driveLow;
            stat.resetActive   <= (state_d == rswc_pkg::RSWC_RDRIVE)
                                | (state_d == rswc_pkg::RSWC_RGAP);
            stat.resetExternal <= ext_d;
            stat.running       <= (state_d == rswc_pkg::RSWC_RUN);
            stat.irqPending    <= irqReq;
            stat.xirqPending   <= xirqReq;
        end
    end

    assign busCycle = busCycle_q;

endmodule

// [tb/rswc_reset_source.sv]
`timescale 1ns/10ps
// ========
// external reset source on an open-drain pin with pull-up
module rswc_reset_source (
    input  wire logic clk,
    input  wire logic resetPinOe,
    input  wire logic resetPinOut,
    output logic      resetPinIn
);
    logic extLow = 1'b0;
    assign resetPinIn = !(extLow || (resetPinOe && !resetPinOut));
    // hold the pin low for n bus cycles
    task automatic pulse(input int n);
        extLow = 1'b1;
        repeat (n * 4) @(posedge clk);
        #1;
        extLow = 1'b0;
    endtask
endmodule

// [tb/rswc_reset_stop_wait_sva.sv]
`timescale 1ns/10ps
// ========
// port checker
module rswc_reset_stop_wait_sva (
    input wire logic                 clk,
    input wire logic                 nrst,
    input wire rswc_pkg::rswc_ctrl_t ctrl,
    input wire logic                 resetPinIn,
    input wire logic                 irqPinN,
    input wire logic                 nonmaskableInterruptPinN,
    input wire logic                 resetPinOut,
    input wire logic                 resetPinOe,
    input wire logic                 busCycle,
    input wire rswc_pkg::rswc_stat_t stat
);
    logic [4:0] oeCnt_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            oeCnt_q <= 5'h00;
        end else begin
            oeCnt_q <= resetPinOe ? oeCnt_q + 5'h01 : 5'h00;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_tick_every_four: assert property (busCycle |=> !busCycle [*3] ##1 busCycle)
        else $error("bus tick spacing wrong");
    a_reset_seen: assert property (!stat.resetActive && !resetPinIn |-> ##[1:5] resetPinOe)
        else $error("reset pin low not taken");
    a_drive_len: assert property (!resetPinOe && oeCnt_q != 5'h00 |-> oeCnt_q == 5'h10)
        else $error("reset drive length wrong");
    a_drive_low: assert property (resetPinOe |-> stat.resetActive && !resetPinOut)
        else $error("reset drive not low");
    a_sample_gap: assert property ($fell(resetPinOe) |->
        stat.resetActive [*7] ##[1:3] !stat.resetActive)
        else $error("reset sample gap wrong");
    a_wait_wake: assert property (ctrl.enterWait && !ctrl.iMask && !ctrl.irqEdgeSelect &&
        !stat.running && !stat.resetActive && !irqPinN |-> ##[1:24] stat.running)
        else $error("wait wake late");
    a_stop_xwake: assert property (ctrl.enterStop && ctrl.xMask && !ctrl.stopExitDelaySelect &&
        !stat.running && !stat.resetActive && !nonmaskableInterruptPinN
        |-> ##[1:28] stat.running)
        else $error("stop wake late");
endmodule
bind rswc_reset_stop_wait rswc_reset_stop_wait_sva rswc_reset_stop_wait_sva_inst (.clk(clk),
    .nrst(nrst), .ctrl(ctrl), .resetPinIn(resetPinIn), .irqPinN(irqPinN),
    .nonmaskableInterruptPinN(nonmaskableInterruptPinN), .resetPinOut(resetPinOut),
    .resetPinOe(resetPinOe), .busCycle(busCycle), .stat(stat));

// [tb/rswc_reset_stop_wait_test.sv]
`timescale 1ns/10ps
// ========
// bench
module rswc_reset_stop_wait_test;
    logic clk, nrst, resetPinIn, irqPinN, xirqPinN, resetPinOut, resetPinOe, busCycle;
    rswc_pkg::rswc_ctrl_t ctrl;
    rswc_pkg::rswc_stat_t stat;
    int bad_count, check_count, cyc;
    rswc_reset_stop_wait rswc_reset_stop_wait_inst (.clk(clk), .nrst(nrst), .ctrl(ctrl),
        .resetPinIn(resetPinIn), .irqPinN(irqPinN), .nonmaskableInterruptPinN(xirqPinN),
        .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .busCycle(busCycle), .stat(stat));
    rswc_reset_source rswc_reset_source_inst (.clk(clk), .resetPinOe(resetPinOe),
        .resetPinOut(resetPinOut), .resetPinIn(resetPinIn));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("bad_count=%0d check_count=%0d", bad_count, check_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic until_run(input logic lvl, input int lim, output int n);
        n = 0;
        while (stat.running !== lvl && n < lim) begin
            tk(1);
            n++;
        end
    endtask
    task automatic t_reset(input int len, input logic ext);
        int n;
        fork
            rswc_reset_source_inst.pulse(len);
        join_none
        tk(8);
        chk(stat.resetActive, 1'b1);
        chk({resetPinOe, resetPinOut}, 2'h2);
        until_run(1'b1, 40, n);
        chk(stat.resetExternal, ext);
        tk(60);
    endtask
    task automatic t_wait(input logic masked);
        int n;
        ctrl = {4'h4, 1'b0, masked};
        until_run(1'b0, 12, n);
        irqPinN = 1'b0;
        tk(1);
        chk(stat.irqPending, !masked);
        until_run(1'b1, 40, n);
        chk(n <= 22, !masked);
        ctrl = 6'h00;
        xirqPinN = 1'b0;
        tk(1);
        chk(stat.xirqPending, 1'b1);
        until_run(1'b1, 40, n);
        chk(stat.running, 1'b1);
        xirqPinN = 1'b1;
        tk(24);
        irqPinN = 1'b1;
        tk(4);
    endtask
    task automatic t_stop(input logic dly, input logic edgeWake);
        int n;
        int t;
        t = dly ? 4064 * 4 : 4 * 4;
        ctrl = {2'h2, dly, edgeWake, !edgeWake, 1'b0};
        until_run(1'b0, 12, n);
        irqPinN = !edgeWake;
        xirqPinN = edgeWake;
        tk(edgeWake ? 4 : 0);
        irqPinN = 1'b1;
        until_run(1'b1, t + 8, n);
        n = n + (edgeWake ? 4 : 0);
        chk(n >= t - 4 && n <= t + 6, 1'b1);
        ctrl = 6'h00;
        xirqPinN = 1'b1;
        tk(8);
    endtask
    task automatic t_wait_reset;
        int n;
        ctrl = 6'h10;
        until_run(1'b0, 12, n);
        fork
            rswc_reset_source_inst.pulse(8);
        join_none
        tk(6);
        chk(resetPinOe, 1'b1);
        ctrl = 6'h00;
        tk(60);
        chk(stat.running, 1'b1);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            finish_test;
        end
    end
    initial begin
        nrst = 1'b0;
        ctrl = 6'h00;
        irqPinN = 1'b1;
        xirqPinN = 1'b1;
        bad_count = 0;
        check_count = 0;
        cyc = 0;
        tk(12);
        nrst = 1'b1;
        tk(8);
        t_reset(8, 1'b1);
        t_reset(1, 1'b0);
        t_wait(1'b0);
        t_wait(1'b1);
        t_stop(1'b0, 1'b0);
        t_stop(1'b0, 1'b1);
        t_stop(1'b1, 1'b0);
        t_wait_reset;
        finish_test;
    end
endmodule
